//--- sim/acs_core_model.sv
/*
 acs_core_model: measurement core seen from the register map, a ring
 buffer of three samples that pops one byte per accepted read.
 Assumes ringPop is only high while a sample is held.
*/
module acs_core_model (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ringPop,
   output logic [7:0] ringData,
   output logic [7:0] ringCount
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] popCnt_q;
   logic [7:0] popCnt_d;
   always_comb begin
      popCnt_d = ringPop ? popCnt_q + 8'h01 : popCnt_q;
   end
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         popCnt_q <= 8'h00;
      end else begin
         popCnt_q <= popCnt_d;
      end
   end
   assign ringCount = 8'h03 - popCnt_q;
   // distinct per sample, so a stale head shows
   assign ringData = 8'hB0 + popCnt_q;
endmodule // acs_core_model

//--- sim/acs_regmap_tb.sv
/*
 acs_regmap_tb: register map bench, host reads and writes by strobes.
 Assumes one-cycle strobes taken at the rising edge, read data one cycle on.
*/
module acs_regmap_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic clkEn = 1'b1;
   logic [7:0] statusIn = 8'h5C;
   logic [7:0] axisZHigh = 8'h32;
   logic bufHalfLevel = 1'b0;
   logic bufFullLevel = 1'b0;
   logic [5:0] hostAddr = 6'h00;
   logic hostWrEn = 1'b0;
   logic hostRdEn = 1'b0;
   logic [7:0] hostWrData = 8'h00;
   logic [7:0] hostRdData;
   logic hostRdValid;
   logic [8:0] tempValue = 9'h155;
   logic [7:0] ringData;
   logic [7:0] ringCount;
   logic ringPop;
   logic freefallEvent = 1'b0;
   logic [2:0] motionEvent = 3'h0;
   logic nvLoad = 1'b0;
   logic [7:0] nvIrqConfig = 8'h00;
   logic nvIndWrEn = 1'b0;
   logic [3:0] nvIndAddr = 4'h0;
   logic [7:0] nvIndData = 8'h00;
   logic [7:0] operatingMode;
   logic [7:0] i2cReadPointer;
   logic [15:0][7:0] indirectRegs;
   logic unlocked;
   logic irqPin;
   int mismatches = 0;
   int cmp_count = 0;

   always #4 mclk = ~mclk;

   acs_regmap dut (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn),
      .hostAddr(hostAddr), .hostWrEn(hostWrEn), .hostRdEn(hostRdEn),
      .hostWrData(hostWrData), .hostRdData(hostRdData),
      .hostRdValid(hostRdValid), .statusIn(statusIn), .axisXLow(8'h11),
      .axisXHigh(8'h12), .axisYLow(8'h21), .axisYHigh(8'h22),
      .axisZLow(8'h31), .axisZHigh(axisZHigh), .tempValue(tempValue),
      .ringData(ringData), .ringCount(ringCount), .ringPop(ringPop),
      .bufHalfLevel(bufHalfLevel), .bufFullLevel(bufFullLevel),
      .freefallEvent(freefallEvent), .motionEvent(motionEvent),
      .nvLoad(nvLoad), .nvIrqConfig(nvIrqConfig), .nvIndWrEn(nvIndWrEn),
      .nvIndAddr(nvIndAddr), .nvIndData(nvIndData),
      .operatingMode(operatingMode), .i2cReadPointer(i2cReadPointer),
      .indirectRegs(indirectRegs), .unlocked(unlocked), .irqPin(irqPin));

   acs_core_model core (.mclk(mclk), .sys_rst(sys_rst), .ringPop(ringPop),
      .ringData(ringData), .ringCount(ringCount));

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(negedge mclk);
      hostAddr = a;
      hostWrData = d;
      hostWrEn = 1'b1;
      @(negedge mclk);
      hostWrEn = 1'b0;
   endtask

   // read data and valid are looked at in their one valid cycle
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      @(negedge mclk);
      hostAddr = a;
      hostRdEn = 1'b1;
      @(negedge mclk);
      hostRdEn = 1'b0;
      chk({7'h00, hostRdValid}, 8'h01);
      chk(hostRdData, exp);
   endtask

   task automatic pulse_events(input logic ff, input logic [2:0] mo);
      @(negedge mclk);
      freefallEvent = ff;
      motionEvent = mo;
      @(negedge mclk);
      freefallEvent = 1'b0;
      motionEvent = 3'h0;
      @(negedge mclk);
   endtask

   // hang guard, far above the run length
   initial begin
      #200000;
      mismatches++;
      report_and_stop();
   end

   initial begin
      repeat (4) @(negedge mclk);
      sys_rst = 1'b0;
      rd(6'h00, 8'h01);
      rd(6'h02, 8'h5C);
      rd(6'h14, 8'h00);
      wr(6'h00, 8'hFF);
      rd(6'h00, 8'h01);
      wr(6'h01, 8'hFF);
      rd(6'h01, 8'h00);
      rd(6'h3F, 8'h00);
      wr(6'h14, 8'h90);
      rd(6'h14, 8'h90);
      chk(operatingMode, 8'h90);
      // clock enable low: strobes ignored, state frozen
      clkEn = 1'b0;
      wr(6'h14, 8'h33);
      clkEn = 1'b1;
      rd(6'h14, 8'h90);
      wr(6'h17, 8'h5A);
      rd(6'h17, 8'h5A);
      chk(i2cReadPointer, 8'h5A);
      rd(6'h04, 8'h11);
      rd(6'h05, 8'h12);
      rd(6'h06, 8'h21);
      rd(6'h07, 8'h22);
      rd(6'h08, 8'h31);
      rd(6'h09, 8'h32);
      axisZHigh = 8'h4E;
      rd(6'h09, 8'h4E);
      statusIn = 8'hA3;
      rd(6'h02, 8'hA3);
      // locked: select and window blocked
      wr(6'h18, 8'h05);
      rd(6'h18, 8'h00);
      rd(6'h22, 8'h00);
      wr(6'h1E, 8'h00);
      wr(6'h1E, 8'h50);
      chk({7'h00, unlocked}, 8'h00);
      wr(6'h1E, 8'hA0);
      chk({7'h00, unlocked}, 8'h01);
      wr(6'h18, 8'h05);
      rd(6'h18, 8'h05);
      wr(6'h22, 8'h3C);
      rd(6'h22, 8'h3C);
      chk(indirectRegs[5], 8'h3C);
      // nonvolatile mirror loads
      @(negedge mclk);
      nvLoad = 1'b1;
      nvIrqConfig = 8'h81;
      nvIndWrEn = 1'b1;
      nvIndAddr = 4'h6;
      nvIndData = 8'h77;
      @(negedge mclk);
      nvLoad = 1'b0;
      nvIndWrEn = 1'b0;
      rd(6'h21, 8'h81);
      wr(6'h18, 8'h06);
      rd(6'h22, 8'h77);
      // wrong key relocks
      wr(6'h1E, 8'h11);
      chk({7'h00, unlocked}, 8'h00);
      wr(6'h22, 8'h55);
      rd(6'h22, 8'h00);
      chk(indirectRegs[6], 8'h77);
      // ring pops one sample per read
      rd(6'h15, 8'h03);
      rd(6'h0F, 8'hB0);
      rd(6'h0F, 8'hB1);
      rd(6'h15, 8'h01);
      // temperature snapshot taken by the high byte
      rd(6'h13, 8'hAA);
      tempValue = 9'h000;
      rd(6'h12, 8'h80);
      // free fall and motion, pin active high
      chk({7'h00, irqPin}, 8'h00);
      pulse_events(1'b1, 3'b101);
      chk({7'h00, irqPin}, 8'h01);
      rd(6'h16, 8'h0D);
      rd(6'h16, 8'h00);
      chk({7'h00, irqPin}, 8'h00);
      // global mask keeps the pin quiet
      wr(6'h21, 8'h85);
      pulse_events(1'b0, 3'b010);
      chk({7'h00, irqPin}, 8'h00);
      rd(6'h16, 8'h02);
      // buffer levels gated by their own enables
      wr(6'h21, 8'h81);
      bufHalfLevel = 1'b1;
      repeat (3) @(negedge mclk);
      chk({7'h00, irqPin}, 8'h00);
      rd(6'h16, 8'h40);
      wr(6'h21, 8'hC1);
      @(negedge mclk);
      chk({7'h00, irqPin}, 8'h01);
      bufHalfLevel = 1'b0;
      bufFullLevel = 1'b1;
      rd(6'h16, 8'hC0);
      rd(6'h16, 8'h80);
      bufFullLevel = 1'b0;
      report_and_stop();
   end
endmodule // acs_regmap_tb

//--- src/acs_pkg.sv
/*
 acs_pkg: offsets, field positions, reset values and key values of the
 acceleration sensor register map. Assumes a 6-bit register address space
 reached through a byte-wide register port.
*/
package acs_pkg;
   // register offsets
   localparam logic [5:0] OFS_REVISION_ID = 6'h00;
   localparam logic [5:0] OFS_DEVICE_STATUS = 6'h02;
   localparam logic [5:0] OFS_AXIS_X_LOW = 6'h04;
   localparam logic [5:0] OFS_AXIS_X_HIGH = 6'h05;
   localparam logic [5:0] OFS_AXIS_Y_LOW = 6'h06;
   localparam logic [5:0] OFS_AXIS_Y_HIGH = 6'h07;
   localparam logic [5:0] OFS_AXIS_Z_LOW = 6'h08;
   localparam logic [5:0] OFS_AXIS_Z_HIGH = 6'h09;
   localparam logic [5:0] OFS_RING_OUTPUT = 6'h0F;
   localparam logic [5:0] OFS_TEMPERATURE_LOW = 6'h12;
   localparam logic [5:0] OFS_TEMPERATURE_HIGH = 6'h13;
   localparam logic [5:0] OFS_OPERATING_MODE = 6'h14;
   localparam logic [5:0] OFS_UNREAD_SAMPLE_COUNT = 6'h15;
   localparam logic [5:0] OFS_IRQ_CAUSE = 6'h16;
   localparam logic [5:0] OFS_I2C_READ_POINTER = 6'h17;
   localparam logic [5:0] OFS_INDIRECT_SELECT = 6'h18;
   localparam logic [5:0] OFS_LOCK_KEY = 6'h1E;
   localparam logic [5:0] OFS_IRQ_CONFIG = 6'h21;
   localparam logic [5:0] OFS_INDIRECT_WINDOW = 6'h22;

   // indirect control register bank
   localparam int IND_AW = 4;
   localparam int IND_DEPTH = 16;

   // operating_mode fields
   localparam int MODE_RING_EN_BIT = 7;
   localparam int MODE_FREEFALL_EN_BIT = 4;

   // irq_config fields
   localparam int CFG_FULL_EN_BIT = 7;
   localparam int CFG_HALF_EN_BIT = 6;
   localparam int CFG_MASK_ALL_BIT = 2;
   localparam int CFG_POLARITY_BIT = 0;

   // irq_cause fields
   localparam int CAUSE_FULL_BIT = 7;
   localparam int CAUSE_HALF_BIT = 6;
   localparam int CAUSE_FREEFALL_BIT = 3;
   localparam int CAUSE_MOTION_LSB = 0;

   // lock_key read-back field
   localparam int KEY_OPEN_BIT = 0;

   // key sequence values
   localparam logic [7:0] KEY_FIRST = 8'h00;
   localparam logic [7:0] KEY_SECOND = 8'h50;
   localparam logic [7:0] KEY_THIRD = 8'hA0;

   // reset values
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_I2C_POINTER = 8'h00;
   localparam logic [7:0] RST_SELECT = 8'h00;
   localparam logic [7:0] RST_IRQ_CONFIG = 8'h00;
   localparam logic [7:0] RST_CAUSE = 8'h00;
   localparam logic [7:0] RST_INDIRECT = 8'h00;
   localparam logic [8:0] RST_TEMP = 9'h000;
   localparam logic [7:0] RST_RDATA = 8'h00;

   typedef enum logic [3:0] {
      KEY_LOCKED = 4'h1,
      KEY_GOT00 = 4'h2,
      KEY_GOT50 = 4'h4,
      KEY_OPEN = 4'h8
   } acs_key_e;
endpackage

//--- src/acs_regmap.sv
/*
 acs_regmap: register map of a three-axis acceleration sensor, with key
 lock, indirect control window, nonvolatile mirror and interrupt cause.
 Assumes the serial front end turns frames into one-cycle register read
 and write strobes, and the measurement core supplies samples and events.
*/
module acs_regmap #(
   // arbitrary value
   parameter logic [7:0] REVISION_ID = 8'h01
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic [5:0] hostAddr,
   input wire logic hostWrEn,
   input wire logic hostRdEn,
   input wire logic [7:0] hostWrData,
   output logic [7:0] hostRdData,
   output logic hostRdValid,
   input wire logic [7:0] statusIn,
   input wire logic [7:0] axisXLow,
   input wire logic [7:0] axisXHigh,
   input wire logic [7:0] axisYLow,
   input wire logic [7:0] axisYHigh,
   input wire logic [7:0] axisZLow,
   input wire logic [7:0] axisZHigh,
   input wire logic [8:0] tempValue,
   input wire logic [7:0] ringData,
   input wire logic [7:0] ringCount,
   output logic ringPop,
   input wire logic bufHalfLevel,
   input wire logic bufFullLevel,
   input wire logic freefallEvent,
   input wire logic [2:0] motionEvent,
   input wire logic nvLoad,
   input wire logic [7:0] nvIrqConfig,
   input wire logic nvIndWrEn,
   input wire logic [3:0] nvIndAddr,
   input wire logic [7:0] nvIndData,
   output logic [7:0] operatingMode,
   output logic [7:0] i2cReadPointer,
   output logic [15:0][7:0] indirectRegs,
   output logic unlocked,
   output logic irqPin
);
   acs_pkg::acs_key_e keyState_q, keyState_d;
   logic [7:0] mode_q, mode_d;
   logic [7:0] i2cPtr_q, i2cPtr_d;
   logic [7:0] indSel_q, indSel_d;
   logic [7:0] irqCfg_q, irqCfg_d;
   logic [7:0] cause_q, cause_d;
   logic [15:0][7:0] ind_q, ind_d;
   logic [8:0] tempSnap_q, tempSnap_d;
   logic [7:0] rdData_q, rdData_d;
   logic rdValid_q, rdValid_d;
   logic irqPin_q, irqPin_d;
   logic isOpen;
   logic wrHit;
   logic rdHit;
   logic [7:0] causeSet;
   logic [7:0] causeEnable;
   logic irqActive;
   localparam int IND_AW_M1 = acs_pkg::IND_AW - 1;

   // select and window are the only lock-guarded addresses
   function automatic logic lockGuarded(input logic [5:0] addr);
      return (addr == acs_pkg::OFS_INDIRECT_SELECT) ||
             (addr == acs_pkg::OFS_INDIRECT_WINDOW);
   endfunction

   assign isOpen = (keyState_q == acs_pkg::KEY_OPEN);
   assign wrHit = clkEn && hostWrEn;
   assign rdHit = clkEn && hostRdEn;

   // pop ring
   // no pop on an empty ring, so the sample stream never skips
   assign ringPop = rdHit && (hostAddr == acs_pkg::OFS_RING_OUTPUT) &&
                    (ringCount != 8'h00);

   always_comb begin
      causeSet = 8'h00;
      causeSet[acs_pkg::CAUSE_FULL_BIT] = bufFullLevel;
      causeSet[acs_pkg::CAUSE_HALF_BIT] = bufHalfLevel;
      causeSet[acs_pkg::CAUSE_FREEFALL_BIT] =
         freefallEvent && mode_q[acs_pkg::MODE_FREEFALL_EN_BIT];
      causeSet[acs_pkg::CAUSE_MOTION_LSB +: 3] = motionEvent;
   end

   always_comb begin
      causeEnable = 8'h00;
      causeEnable[acs_pkg::CAUSE_FULL_BIT] =
         irqCfg_q[acs_pkg::CFG_FULL_EN_BIT];
      causeEnable[acs_pkg::CAUSE_HALF_BIT] =
         irqCfg_q[acs_pkg::CFG_HALF_EN_BIT];
      causeEnable[acs_pkg::CAUSE_FREEFALL_BIT] = 1'b1;
      causeEnable[acs_pkg::CAUSE_MOTION_LSB +: 3] = 3'h7;
      irqActive = ((cause_q & causeEnable) != 8'h00) &&
                  !irqCfg_q[acs_pkg::CFG_MASK_ALL_BIT];
   end

   always_comb begin
      keyState_d = keyState_q;
      mode_d = mode_q;
      i2cPtr_d = i2cPtr_q;
      indSel_d = indSel_q;
      irqCfg_d = irqCfg_q;
      ind_d = ind_q;
      tempSnap_d = tempSnap_q;
      rdData_d = rdData_q;
      rdValid_d = rdHit;
      cause_d = cause_q;
      if (nvLoad) begin
         irqCfg_d = nvIrqConfig;
      end
      if (nvIndWrEn) begin
         ind_d[nvIndAddr] = nvIndData;
      end
      // reserved and read-only writes fall through
      if (wrHit) begin
         unique case (hostAddr)
            acs_pkg::OFS_OPERATING_MODE: mode_d = hostWrData;
            acs_pkg::OFS_I2C_READ_POINTER: i2cPtr_d = hostWrData;
            acs_pkg::OFS_IRQ_CONFIG: irqCfg_d = hostWrData;
            acs_pkg::OFS_INDIRECT_SELECT: begin
               if (isOpen) begin
                  indSel_d = hostWrData;
               end
            end
            acs_pkg::OFS_INDIRECT_WINDOW: begin
               if (isOpen) begin
                  ind_d[indSel_q[IND_AW_M1:0]] = hostWrData;
               end
            end
            acs_pkg::OFS_LOCK_KEY: begin
               if (hostWrData == acs_pkg::KEY_FIRST) begin
                  keyState_d = acs_pkg::KEY_GOT00;
               end else if (hostWrData == acs_pkg::KEY_SECOND &&
                            keyState_q == acs_pkg::KEY_GOT00) begin
                  keyState_d = acs_pkg::KEY_GOT50;
               end else if (hostWrData == acs_pkg::KEY_THIRD &&
                            keyState_q == acs_pkg::KEY_GOT50) begin
                  keyState_d = acs_pkg::KEY_OPEN;
               end else begin
                  keyState_d = acs_pkg::KEY_LOCKED;
               end
            end
            default: ;
         endcase
      end
      if (rdHit) begin
         rdData_d = 8'h00;
         unique case (hostAddr)
            acs_pkg::OFS_REVISION_ID: rdData_d = REVISION_ID;
            acs_pkg::OFS_DEVICE_STATUS: rdData_d = statusIn;
            acs_pkg::OFS_AXIS_X_LOW: rdData_d = axisXLow;
            acs_pkg::OFS_AXIS_X_HIGH: rdData_d = axisXHigh;
            acs_pkg::OFS_AXIS_Y_LOW: rdData_d = axisYLow;
            acs_pkg::OFS_AXIS_Y_HIGH: rdData_d = axisYHigh;
            acs_pkg::OFS_AXIS_Z_LOW: rdData_d = axisZLow;
            acs_pkg::OFS_AXIS_Z_HIGH: rdData_d = axisZHigh;
            acs_pkg::OFS_RING_OUTPUT: rdData_d = ringData;
            acs_pkg::OFS_TEMPERATURE_HIGH: begin
               tempSnap_d = tempValue;
               rdData_d = tempValue[8:1];
            end
            acs_pkg::OFS_TEMPERATURE_LOW: rdData_d = {tempSnap_q[0], 7'h00};
            acs_pkg::OFS_OPERATING_MODE: rdData_d = mode_q;
            acs_pkg::OFS_UNREAD_SAMPLE_COUNT: rdData_d = ringCount;
            acs_pkg::OFS_IRQ_CAUSE: begin
               rdData_d = cause_q;
               cause_d = acs_pkg::RST_CAUSE;
            end
            acs_pkg::OFS_I2C_READ_POINTER: rdData_d = i2cPtr_q;
            acs_pkg::OFS_LOCK_KEY: rdData_d[acs_pkg::KEY_OPEN_BIT] = isOpen;
            acs_pkg::OFS_IRQ_CONFIG: rdData_d = irqCfg_q;
            acs_pkg::OFS_INDIRECT_SELECT:
               rdData_d = isOpen ? indSel_q : 8'h00;
            acs_pkg::OFS_INDIRECT_WINDOW:
               rdData_d = isOpen ? ind_q[indSel_q[IND_AW_M1:0]] : 8'h00;
            default: ;
         endcase
      end
      cause_d = cause_d | causeSet;
      irqPin_d = irqCfg_d[acs_pkg::CFG_POLARITY_BIT] ? irqActive :
                 !irqActive;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         keyState_q <= acs_pkg::KEY_LOCKED;
         mode_q <= acs_pkg::RST_MODE;
         i2cPtr_q <= acs_pkg::RST_I2C_POINTER;
         indSel_q <= acs_pkg::RST_SELECT;
         irqCfg_q <= acs_pkg::RST_IRQ_CONFIG;
         ind_q <= {acs_pkg::IND_DEPTH{acs_pkg::RST_INDIRECT}};
         tempSnap_q <= acs_pkg::RST_TEMP;
         rdData_q <= acs_pkg::RST_RDATA;
         rdValid_q <= 1'b0;
         cause_q <= acs_pkg::RST_CAUSE;
         irqPin_q <= 1'b1;
      end else if (clkEn) begin
         keyState_q <= keyState_d;
         mode_q <= mode_d;
         i2cPtr_q <= i2cPtr_d;
         indSel_q <= indSel_d;
         irqCfg_q <= irqCfg_d;
         ind_q <= ind_d;
         tempSnap_q <= tempSnap_d;
         rdData_q <= rdData_d;
         rdValid_q <= rdValid_d;
         cause_q <= cause_d;
         irqPin_q <= irqPin_d;
      end
   end

   assign hostRdData = rdData_q;
   assign hostRdValid = rdValid_q;
   assign operatingMode = mode_q;
   assign i2cReadPointer = i2cPtr_q;
   assign indirectRegs = ind_q;
   assign unlocked = isOpen;
   assign irqPin = irqPin_q;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   sequence keyWrite(logic [7:0] val);
      clkEn && hostWrEn && !hostRdEn && !nvLoad &&
      hostAddr == acs_pkg::OFS_LOCK_KEY && hostWrData == val;
   endsequence

   // one idle cycle between reads, as the host port paces them
   sequence tempHighThenLow;
      (rdHit && hostAddr == acs_pkg::OFS_TEMPERATURE_HIGH) ##1
      !(rdHit && hostAddr == acs_pkg::OFS_TEMPERATURE_HIGH) ##1
      (rdHit && hostAddr == acs_pkg::OFS_TEMPERATURE_LOW);
   endsequence

   sequence keyIdle;
      !(clkEn && hostWrEn && hostAddr == acs_pkg::OFS_LOCK_KEY);
   endsequence

   lock_blocks_write_a: assert property (
      wrHit && lockGuarded(hostAddr) && !isOpen && !nvIndWrEn |=>
         $stable(indSel_q) && $stable(ind_q))
      else $error("locked select or window was written");

   lock_blocks_read_a: assert property (
      rdHit && lockGuarded(hostAddr) && !isOpen |=>
         hostRdValid && hostRdData == 8'h00)
      else $error("locked select or window was readable");

   window_route_a: assert property (
      wrHit && isOpen && hostAddr == acs_pkg::OFS_INDIRECT_WINDOW &&
      !nvIndWrEn |=>
         ind_q[$past(indSel_q[IND_AW_M1:0])] == $past(hostWrData))
      else $error("window write missed the selected register");

   select_store_a: assert property (
      wrHit && isOpen && hostAddr == acs_pkg::OFS_INDIRECT_SELECT |=>
         indSel_q == $past(hostWrData))
      else $error("select register did not take the write");

   nv_mirror_a: assert property (
      clkEn && nvLoad &&
      !(hostWrEn && hostAddr == acs_pkg::OFS_IRQ_CONFIG) |=>
         irqCfg_q == $past(nvIrqConfig))
      else $error("irq config not loaded from mirror");

   mode_store_a: assert property (
      wrHit && hostAddr == acs_pkg::OFS_OPERATING_MODE |=>
         operatingMode == $past(hostWrData))
      else $error("mode register did not take the write");

   count_read_a: assert property (
      rdHit && hostAddr == acs_pkg::OFS_UNREAD_SAMPLE_COUNT |=>
         hostRdValid && hostRdData == $past(ringCount))
      else $error("count read wrong");

   cause_set_a: assert property (
      clkEn && motionEvent[0] |=> cause_q[acs_pkg::CAUSE_MOTION_LSB])
      else $error("motion cause lost");

   cause_sticky_a: assert property (
      cause_q[acs_pkg::CAUSE_MOTION_LSB] &&
      !(rdHit && hostAddr == acs_pkg::OFS_IRQ_CAUSE) |=>
         cause_q[acs_pkg::CAUSE_MOTION_LSB])
      else $error("motion cause cleared without a read");

   revision_read_a: assert property (
      rdHit && hostAddr == acs_pkg::OFS_REVISION_ID |=>
         hostRdData == REVISION_ID)
      else $error("revision read wrong");

   ring_pop_a: assert property (
      rdHit && hostAddr == acs_pkg::OFS_RING_OUTPUT &&
      ringCount != 8'h00 |-> ringPop ##1 hostRdData == $past(ringData))
      else $error("ring read did not pop the sample");

   unlock_seq_a: assert property (
      keyWrite(acs_pkg::KEY_FIRST) ##1 keyIdle ##1
      keyWrite(acs_pkg::KEY_SECOND) ##1 keyIdle ##1
      keyWrite(acs_pkg::KEY_THIRD) |=> unlocked)
      else $error("key sequence did not unlock");

   temp_order_a: assert property (
      tempHighThenLow |=> hostRdData[7] == $past(tempValue[0], 3))
      else $error("low temperature byte not from snapshot");

   cause_ack_a: assert property (
      rdHit && hostAddr == acs_pkg::OFS_IRQ_CAUSE && causeSet == 8'h00 |=>
         cause_q == 8'h00 && hostRdData == $past(cause_q))
      else $error("cause read did not acknowledge");

   reserved_zero_a: assert property (
      rdHit && hostAddr == 6'h3F |=> hostRdValid && hostRdData == 8'h00)
      else $error("reserved address read nonzero");

   axis_read_a: assert property (
      rdHit && hostAddr == acs_pkg::OFS_AXIS_Z_HIGH |=>
         hostRdData == $past(axisZHigh))
      else $error("axis byte read wrong");
endmodule // acs_regmap
